/* File: shared/mpb_cfg.svh */
// Constants for the microcontroller parallel bus port
`ifndef MPB_CFG_SVH
`define MPB_CFG_SVH
`define MPB_WIDTH 16
`define MPB_PAGE_W 8
`define MPB_SEG_W 4
`define MPB_NSEG 16
`define MPB_RST_PAGE 8'h00
`define MPB_RST_ADDR 16'h0000
`define MPB_RST_DATA 16'h0000
`endif

/* File: shared/mpb_pkg.sv */
// Types for the microcontroller parallel bus port
package mpb_pkg;
   typedef enum logic [1:0]
   {
      MPB_C0_WR_N = 2'b00,
      MPB_C0_RW = 2'b01,
      MPB_C0_WRL_N = 2'b10
   } mpb_c0_mode_t;
   typedef enum logic [1:0]
   {
      MPB_C1_RD_N = 2'b00,
      MPB_C1_E = 2'b01,
      MPB_C1_DS_N = 2'b10,
      MPB_C1_LDS_N = 2'b11
   } mpb_c1_mode_t;
   typedef enum logic [1:0]
   {
      MPB_BUS_MUX = 2'b00,
      MPB_BUS_NONMUX = 2'b01,
      MPB_BUS_BURST = 2'b10
   } mpb_bus_mode_t;
   typedef enum logic
   {
      MPB_LAT_ALE = 1'b0,
      MPB_LAT_AS = 1'b1
   } mpb_lat_mode_t;
   typedef struct packed
   {
      mpb_bus_mode_t bus;
      mpb_lat_mode_t lat;
      mpb_c0_mode_t c0;
      mpb_c1_mode_t c1;
   } mpb_cfg_t;
   typedef struct packed
   {
      logic [7:0] page;
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic ctl0;
      logic ctl1;
   } mpb_fwd_t;
   typedef enum logic [1:0]
   {
      MPB_SEL_NONE = 2'b00,
      MPB_SEL_PRIMARY = 2'b01,
      MPB_SEL_SECONDARY = 2'b10,
      MPB_SEL_LOGIC = 2'b11
   } mpb_sel_t;
endpackage

/* File: design/mpb_port.sv */
// Host parallel bus port with decode, page register and dual-array control
`include "mpb_cfg.svh"
module mpb_port
   import mpb_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Static configuration, held stable before bus activity
   input wire mpb_cfg_t cfg,
   // Host pins
   input wire logic [15:0] addr_data_pins_in,
   output logic [15:0] addr_data_pins_out,
   output logic [15:0] addr_data_pins_oe,
   input wire logic address_strobe,
   input wire logic control_pin_0,
   input wire logic control_pin_1,
   input wire logic chip_select_n,
   // Segment map: one base segment per memory, and update controls
   input wire logic [3:0] primary_seg,
   input wire logic [3:0] secondary_seg,
   input wire logic [3:0] logic_seg,
   input wire logic secondary_hide,
   input wire logic flash_as_data,
   // Read data from memories
   input wire logic [15:0] primary_rdata,
   input wire logic [15:0] secondary_rdata,
   input wire logic [15:0] logic_rdata,
   // Flash array busy flags (erase or program in progress)
   input wire logic primary_busy,
   input wire logic secondary_busy,
   // Test-access port programming path
   input wire logic tap_prog_en,
   input wire logic tap_wr,
   input wire logic [15:0] tap_addr,
   input wire logic [15:0] tap_wdata,
   input wire logic tap_sel_secondary,
   // Forwarding to decode and logic arrays
   output mpb_fwd_t fwd,
   output mpb_sel_t sel,
   output logic code_space,
   output logic mem_wr,
   output logic [15:0] mem_wdata,
   output logic mem_wr_secondary,
   output logic read_stall
);

   // ==========================================================
   // Configuration capture
   // The wiring selection is taken only while reset is held, so inputs
   // that move later cannot change the decode in the middle of a cycle.
   mpb_cfg_t cfg_q;
   mpb_cfg_t next_cfg_q;

   always_comb
   begin
      next_cfg_q = cfg_q;
      if (sys_rst)
         next_cfg_q = cfg;
   end

   always_ff @(posedge mclk)
   begin
      cfg_q <= next_cfg_q;
   end

   // ==========================================================
   // Control decode
   logic rd_act;
   logic wr_act;
   logic lat_prev;
   logic next_lat_prev;
   logic [15:0] addr;
   logic [15:0] next_addr;
   logic [7:0] page;
   logic [7:0] next_page;
   logic [15:0] cur_addr;
   logic [3:0] seg;
   mpb_sel_t dec_sel;

   always_comb
   begin
      rd_act = 1'b0;
      wr_act = 1'b0;
      // With a direction line the strobe alone starts a cycle; the
      // direction level by itself never does
      unique case (cfg_q.c1)
         MPB_C1_RD_N: rd_act = ~control_pin_1;
         MPB_C1_E: rd_act = control_pin_1 & (cfg_q.c0 == MPB_C0_RW)
                            & control_pin_0;
         MPB_C1_DS_N,
         MPB_C1_LDS_N: rd_act = ~control_pin_1 & (cfg_q.c0 == MPB_C0_RW)
                                & control_pin_0;
      endcase
      unique case (cfg_q.c0)
         MPB_C0_WR_N,
         MPB_C0_WRL_N: wr_act = ~control_pin_0;
         MPB_C0_RW: wr_act = ~control_pin_0 & ((cfg_q.c1 == MPB_C1_E)
                             ? control_pin_1 : ~control_pin_1);
         default: wr_act = 1'b0;
      endcase
   end

   // ==========================================================
   // Address capture
   // Latch input is sampled; its edges are seen one cycle late, which
   // the host address hold time covers at this clock rate.
   always_comb
   begin
      next_lat_prev = address_strobe;
      next_addr = addr;
      if (cfg_q.bus == MPB_BUS_NONMUX)
      begin
         // Pins track the address until a strobe; the held copy then
         // keeps decode steady while the same pins carry data
         if (!(rd_act || wr_act))
            next_addr = addr_data_pins_in;
      end
      else if (cfg_q.lat == MPB_LAT_AS)
      begin
         if (address_strobe & ~lat_prev)
            next_addr = addr_data_pins_in;
      end
      else if (address_strobe)
         next_addr = addr_data_pins_in;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         // Reset as if the strobe were high, so an idle-high strobe
         // does not look like a rising edge right after reset
         lat_prev <= 1'b1;
         addr <= `MPB_RST_ADDR;
      end
      else
      begin
         lat_prev <= next_lat_prev;
         addr <= next_addr;
      end
   end

   // Non-multiplexed hosts present address directly on the pins
   assign cur_addr = (cfg_q.bus == MPB_BUS_NONMUX && !(rd_act || wr_act))
                     ? addr_data_pins_in : addr;
   assign seg = cur_addr[15:12];

   // ==========================================================
   // Segment decode
   always_comb
   begin
      // Logic wins overlaps so the page register stays reachable
      // whatever the flash map looks like
      dec_sel = MPB_SEL_NONE;
      if (!chip_select_n)
      begin
         if (seg == logic_seg)
            dec_sel = MPB_SEL_LOGIC;
         else if (seg == secondary_seg && !secondary_hide)
            dec_sel = MPB_SEL_SECONDARY;
         else if (seg == primary_seg)
            dec_sel = MPB_SEL_PRIMARY;
      end
   end

   // ==========================================================
   // Page register, written at the top address of the logic segment
   always_comb
   begin
      next_page = page;
      if (wr_act && dec_sel == MPB_SEL_LOGIC && cur_addr[11:0] == 12'hfff)
         next_page = addr_data_pins_in[7:0];
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         page <= `MPB_RST_PAGE;
      else
         page <= next_page;
   end

   // ==========================================================
   // Read side and forwarding
   logic [15:0] next_out;
   logic next_drive;
   mpb_fwd_t next_fwd;
   mpb_sel_t next_sel;
   logic next_code;
   logic next_stall;
   logic tgt_busy;

   always_comb
   begin
      tgt_busy = (dec_sel == MPB_SEL_PRIMARY) ? primary_busy
               : (dec_sel == MPB_SEL_SECONDARY) ? secondary_busy : 1'b0;
      next_out = `MPB_RST_DATA;
      unique case (dec_sel)
         MPB_SEL_PRIMARY: next_out = primary_rdata;
         MPB_SEL_SECONDARY: next_out = secondary_rdata;
         MPB_SEL_LOGIC: next_out = logic_rdata;
         MPB_SEL_NONE: next_out = `MPB_RST_DATA;
      endcase
      // Reads of a busy array are stalled; the other array stays readable
      next_stall = rd_act & tgt_busy;
      // The test port owns the memories, so the host bus stays released
      next_drive = rd_act && dec_sel != MPB_SEL_NONE && !tap_prog_en;
      next_fwd.page = page;
      next_fwd.addr = cur_addr;
      next_fwd.rd = rd_act;
      next_fwd.wr = wr_act;
      next_fwd.ctl0 = control_pin_0;
      next_fwd.ctl1 = control_pin_1;
      next_sel = dec_sel;
      // Reclassified flash is data space; logic and unselected accesses are never code
      next_code = ~flash_as_data & (dec_sel == MPB_SEL_PRIMARY
                                  || dec_sel == MPB_SEL_SECONDARY);
      if (tap_prog_en)
      begin
         next_fwd.addr = tap_addr;
         next_sel = MPB_SEL_NONE;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         addr_data_pins_out <= `MPB_RST_DATA;
         fwd <= '0;
         sel <= MPB_SEL_NONE;
         code_space <= 1'b0;
         read_stall <= 1'b0;
      end
      else
      begin
         addr_data_pins_out <= next_out;
         fwd <= next_fwd;
         sel <= next_sel;
         code_space <= next_code;
         read_stall <= next_stall;
      end
   end

   // One enable flop per pin; all share one decision, so the bus turns
   // around as a whole word and never splits between bytes
   for (genvar i = 0; i < `MPB_WIDTH; i++)
   begin : g_oe
      always_ff @(posedge mclk)
      begin
         if (sys_rst)
            addr_data_pins_oe[i] <= 1'b0;
         else
            addr_data_pins_oe[i] <= next_drive;
      end
   end

   // ==========================================================
   // Write side
   logic next_mem_wr;
   logic [15:0] next_wdata;
   logic next_wr_sec;

   always_comb
   begin
      next_mem_wr = 1'b0;
      next_wdata = addr_data_pins_in;
      next_wr_sec = dec_sel == MPB_SEL_SECONDARY;
      if (tap_prog_en)
      begin
         // Test port overrides the host flash write path, so blank parts program; host page writes still land
         next_mem_wr = tap_wr;
         next_wdata = tap_wdata;
         next_wr_sec = tap_sel_secondary;
      end
      else if (wr_act && (dec_sel == MPB_SEL_PRIMARY
                          || dec_sel == MPB_SEL_SECONDARY))
         // Flash stays read-only to the host until it is reclassified
         next_mem_wr = flash_as_data;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         mem_wr <= 1'b0;
         mem_wdata <= `MPB_RST_DATA;
         mem_wr_secondary <= 1'b0;
      end
      else
      begin
         mem_wr <= next_mem_wr;
         mem_wdata <= next_wdata;
         mem_wr_secondary <= next_wr_sec;
      end
   end
endmodule

/* File: tb/mpb_host_model.sv */
// Host model for the multiplexed address/data bus
module mpb_host_model
(
   // Clock and control wiring
   input wire logic mclk,
   input wire logic rw_mode,
   input wire logic e_mode,
   // Bus pins
   output logic ale = 1'b0,
   output logic c0 = 1'b1,
   output wire logic c1,
   output logic [15:0] drv = 16'h0000,
   output logic en = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic strobe = 1'b0;
   // Phase clock is active high, every other strobe active low
   assign c1 = e_mode ? strobe : !strobe;
   // ==========
   // Bus cycle
   task automatic cycle(input logic [15:0] a, input logic wr,
      input logic [15:0] d);
      @(posedge mclk);
      ale <= 1'b1;
      drv <= a;
      en <= 1'b1;
      @(posedge mclk);
      ale <= 1'b0;
      @(posedge mclk);
      // Address is released on the same edge that asserts the read strobe; the port drives a cycle later
      drv <= d;
      en <= wr;
      c0 <= !wr;
      strobe <= rw_mode || !wr;
      repeat (3) @(posedge mclk);
      c0 <= 1'b1;
      strobe <= 1'b0;
      en <= 1'b0;
      @(posedge mclk);
   endtask
endmodule

/* File: tb/mpb_port_monitor.sv */
// Port checker for the host parallel bus port
module mpb_port_monitor
   import mpb_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic chip_select_n,
   input wire logic secondary_hide,
   input wire logic flash_as_data,
   input wire logic tap_prog_en,
   input wire logic tap_wr,
   input wire logic [15:0] tap_wdata,
   input wire logic [15:0] addr_data_pins_oe,
   input wire mpb_fwd_t fwd,
   input wire mpb_sel_t sel,
   input wire logic code_space,
   input wire logic mem_wr,
   input wire logic [15:0] mem_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ==========
   // Assertions
   a_oe_whole: assert property (addr_data_pins_oe == 16'h0000 ||
      addr_data_pins_oe == 16'hffff) else $error("oe split");
   a_cs_blocks: assert property ($past(chip_select_n) |->
      sel == MPB_SEL_NONE && addr_data_pins_oe == 16'h0000)
      else $error("cs high access");
   a_oe_selected: assert property (addr_data_pins_oe[0] |->
      sel != MPB_SEL_NONE && fwd.rd) else $error("drive unselected");
   a_hide_secondary: assert property ($past(secondary_hide) |->
      sel != MPB_SEL_SECONDARY) else $error("hidden selected");
   a_data_space: assert property ($past(flash_as_data) |->
      !code_space) else $error("code space");
   a_tap_quiet: assert property ($past(tap_prog_en) |->
      addr_data_pins_oe == 16'h0000) else $error("drive in tap");
   a_tap_write: assert property (!$past(sys_rst) &&
      $past(tap_prog_en && tap_wr) |-> mem_wr &&
      mem_wdata == $past(tap_wdata)) else $error("tap write");
   a_oe_release: assert property (addr_data_pins_oe[0] &&
      chip_select_n |=> !addr_data_pins_oe[0]) else $error("oe held");
   c_read: cover property (addr_data_pins_oe[0]);
   c_logic: cover property (sel == MPB_SEL_LOGIC);
   c_tap: cover property (mem_wr && tap_prog_en);
endmodule
bind mpb_port mpb_port_monitor u_mon (.*);

/* File: tb/tb.sv */
// Self-checking bench for the host parallel bus port
module tb
   import mpb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Pins and state
   logic mclk = 1'b0, sys_rst = 1'b1, chip_select_n = 1'b0;
   logic secondary_hide = 1'b0, flash_as_data = 1'b0;
   logic primary_busy = 1'b0, secondary_busy = 1'b0, oe_q = 1'b0;
   logic tap_prog_en = 1'b0, tap_wr = 1'b0, tap_sel_secondary = 1'b0;
   logic [3:0] primary_seg = 4'h0, secondary_seg = 4'h4, logic_seg = 4'h8;
   logic [15:0] primary_rdata = 16'h0000, secondary_rdata = 16'h0000;
   logic [15:0] logic_rdata = 16'h0000, tap_addr = 16'h0000;
   logic [15:0] tap_wdata = 16'h0000, h_d, last = 16'h0000;
   logic [15:0] addr_data_pins_in, addr_data_pins_out, addr_data_pins_oe;
   logic [15:0] mem_wdata;
   logic address_strobe, control_pin_0, control_pin_1, h_en, code_space;
   logic mem_wr, mem_wr_secondary, read_stall;
   mpb_fwd_t fwd;
   mpb_sel_t sel;
   mpb_cfg_t cfg = '{MPB_BUS_MUX, MPB_LAT_ALE, MPB_C0_WR_N, MPB_C1_RD_N};
   mpb_cfg_t cfgs[5] = '{
      '{MPB_BUS_MUX, MPB_LAT_ALE, MPB_C0_WR_N, MPB_C1_RD_N},
      '{MPB_BUS_BURST, MPB_LAT_AS, MPB_C0_RW, MPB_C1_E},
      '{MPB_BUS_NONMUX, MPB_LAT_ALE, MPB_C0_RW, MPB_C1_DS_N},
      '{MPB_BUS_MUX, MPB_LAT_AS, MPB_C0_RW, MPB_C1_LDS_N},
      '{MPB_BUS_MUX, MPB_LAT_ALE, MPB_C0_WRL_N, MPB_C1_RD_N}};
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [7:0] pg;
   int seed = 41941, miscompares = 0, num_checks = 0;
   always #25 mclk = ~mclk;
   // A released bus shows the inverse of its last level
   assign addr_data_pins_in = addr_data_pins_oe[0] ? addr_data_pins_out :
      h_en ? h_d : ~last;
   always @(posedge mclk) last <= addr_data_pins_in;
   mpb_port dut (.*);
   mpb_host_model host (.mclk(mclk), .rw_mode(cfg.c0 == MPB_C0_RW),
      .e_mode(cfg.c1 == MPB_C1_E), .ale(address_strobe),
      .c0(control_pin_0), .c1(control_pin_1), .drv(h_d), .en(h_en));
   // ==========
   // Tasks
   task automatic check(input string n, input logic [15:0] x,
      input logic [15:0] s);
      num_checks++;
      if (s !== x)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic rd(input logic [3:0] sg, input logic [15:0] d,
      input logic st);
      logic [15:0] a;
      a = {sg, 1'b0, 11'($random(seed))};
      exp_q.push_back({st, a, d});
      host.cycle(a, 1'b0, 16'h0000);
   endtask
   // ==========
   // Observer: any drive without a pending read is a mismatch
   always @(posedge mclk)
   begin
      oe_q <= addr_data_pins_oe[0];
      if (addr_data_pins_oe[0] === 1'b1 && oe_q === 1'b0)
      begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
         check("rdata", e[15:0], addr_data_pins_out);
         check("addr", e[31:16], fwd.addr);
         check("stall", {15'h0000, e[32]}, {15'h0000, read_stall});
      end
   end
   // ==========
   // Sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int m = 0; m < 5; m++)
      begin
         if (m > 0)
         begin
            // Wiring is only changed under a reset in mid-run
            sys_rst <= 1'b1;
            cfg <= cfgs[m];
            repeat (2) @(posedge mclk);
            sys_rst <= 1'b0;
            @(posedge mclk);
         end
         for (int k = 0; k < 4; k++)
         begin
            @(posedge mclk);
            primary_seg <= 4'(k);
            secondary_seg <= 4'(k + 4);
            logic_seg <= 4'(k + 8);
            primary_busy <= (k == 1);
            primary_rdata <= 16'($random(seed));
            secondary_rdata <= 16'($random(seed));
            logic_rdata <= 16'($random(seed));
            @(posedge mclk);
            rd(primary_seg, primary_rdata, k == 1);
            rd(secondary_seg, secondary_rdata, 1'b0);
            rd(logic_seg, logic_rdata, 1'b0);
         end
         primary_busy <= 1'b0;
         pg = 8'($random(seed));
         host.cycle({logic_seg, 12'hfff}, 1'b1, {8'h00, pg});
         @(negedge mclk);
         check("page", {8'h00, pg}, {8'h00, fwd.page});
         @(posedge mclk);
      end
      secondary_hide <= 1'b1;
      host.cycle({secondary_seg, 12'h010}, 1'b0, 16'h0000);
      secondary_hide <= 1'b0;
      chip_select_n <= 1'b1;
      host.cycle({primary_seg, 12'h020}, 1'b0, 16'h0000);
      chip_select_n <= 1'b0;
      @(posedge mclk);
      flash_as_data <= 1'b1;
      tap_prog_en <= 1'b1;
      tap_wr <= 1'b1;
      tap_addr <= 16'($random(seed));
      tap_wdata <= 16'($random(seed));
      tap_sel_secondary <= 1'($random(seed));
      repeat (2) @(negedge mclk);
      check("wr", 16'h0001, {15'h0000, mem_wr});
      check("wdata", tap_wdata, mem_wdata);
      check("wsec", {15'h0000, tap_sel_secondary},
         {15'h0000, mem_wr_secondary});
      check("taddr", tap_addr, fwd.addr);
      check("space", 16'h0000, {15'h0000, code_space});
      @(posedge mclk);
      tap_prog_en <= 1'b0;
      tap_wr <= 1'b0;
      check("left", 16'h0000, 16'(exp_q.size()));
      wrap_up();
   end
   initial
   begin
      #200us;
      miscompares++;
      wrap_up();
   end
endmodule
